//--- common/cfg_loader_pkg.sv
// Purpose: Shared constants and types for the bitstream configuration loader
// Assumes: System clock of 25 MHz
// Notes:   Opcodes are the usual serial flash values and may be overridden here
package cfg_loader_pkg;

  typedef enum logic [1:0] {
    MODE_ACTIVE  = 2'h0,
    MODE_PASSIVE = 2'h1,
    MODE_JTAG    = 2'h2,
    MODE_RSVD    = 2'h3
  } cfg_mode_t;

  typedef struct packed {
    cfg_mode_t  mode;
    logic [2:0] wcode;
  } strap_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [31:0] data;
  } cell_wr_t;

  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_WAIT_US  = 30;
  localparam int WAKE_WAIT_CYC = (WAKE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W        = $clog2(WAKE_WAIT_CYC + 1);

  localparam int SCLK_HALF   = 4;
  localparam int SLOT_CYC    = 2 * SCLK_HALF;
  localparam int CMD_BITS    = 8;
  localparam int HDR_BITS    = 32;
  localparam int DUMMY_SLOTS = 8;
  localparam int WORD_BITS   = 32;
  localparam int ADDR_W      = 16;

  localparam logic [7:0]  WAKE_OPCODE      = 8'hab;
  localparam logic [7:0]  FAST_READ_OPCODE = 8'h0b;
  localparam logic [23:0] READ_START_ADDR  = 24'h000000;

  // Width code is log2 of the lane count: 0 = x1 ... 5 = x32
  localparam logic [2:0] WCODE_X1         = 3'h0;
  localparam logic [2:0] WCODE_X2         = 3'h1;
  localparam logic [2:0] WCODE_ACTIVE_MAX = 3'h2;
  localparam logic [2:0] WCODE_MAX        = 3'h5;

endpackage

//--- design/cfg_cell_mem.sv
// Purpose: Configuration cell storage, one write port and one registered read port
// Assumes: Single clock, synchronous active-low reset on the read register
// Notes:   Writes outside the depth are dropped
`timescale 1ns/1ps
`default_nettype none
module cfg_cell_mem #(
  parameter int DEPTH = 1024
) (
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  input  wire cfg_loader_pkg::cell_wr_t       wr_in,
  input  wire logic [cfg_loader_pkg::ADDR_W-1:0] rd_addr_in,
  output logic      [31:0]                    rd_data_out
);
  localparam int IW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > (1 << cfg_loader_pkg::ADDR_W)) begin : g_bad_depth
    $error("cfg_cell_mem: DEPTH out of range");
  end

  logic [31:0] cells [DEPTH];

  wire wr_ok = wr_in.en && (32'(wr_in.addr) < DEPTH);
  wire rd_ok = 32'(rd_addr_in) < DEPTH;

  always_ff @(posedge clk_in) begin
    if (wr_ok) begin
      cells[wr_in.addr[IW-1:0]] <= wr_in.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in || !rd_ok) begin
      rd_data_out <= 32'h0;
    end else begin
      rd_data_out <= cells[rd_addr_in[IW-1:0]];
    end
  end
endmodule
`default_nettype wire

//--- design/cfg_bitstream_loader.sv
// Purpose: Loads a configuration bitstream into cell memory in active, passive or JTAG mode
// Assumes: sys_clk_in at 25 MHz; link_clk_in supplied by the external master
// Notes:   Active mode drives the flash clock from a divider of sys_clk_in
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Load starts on rising edge of cfg_reset_low, held low beforehand.
// - Cells are programmed from the bitstream; user mode only after completion.
// - Active mode is master; flash clock divided from own clock.
// - Active load first sends a wake-from-power-down instruction.
// - At least 30 us pass between wake-up and read command.
// - Fast read from 24-bit address zero, sequential.
// - Bitstream can also arrive over the JTAG path.
// - Widths: active 1/2/4, passive 1 to 32, JTAG 1.
module cfg_bitstream_loader #(
  parameter int BITSTREAM_WORDS = 1024
) (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        cfg_reset_low_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [2:0]  width_in,
  input  wire logic [3:0]  spi_io_in,
  input  wire logic        link_clk_in,
  input  wire logic        link_sel_low_in,
  input  wire logic [31:0] link_data_in,
  input  wire logic [15:0] user_rd_addr_in,
  output logic             spi_clk_out,
  output logic             spi_cs_low_out,
  output logic      [3:0]  spi_io_out,
  output logic      [3:0]  spi_io_oe_out,
  output logic             cfg_done_out,
  output logic             user_enable_out,
  output logic      [31:0] user_rd_data_out
);
  if (BITSTREAM_WORDS < 2 || BITSTREAM_WORDS > 65536) begin : g_bad_words
    $error("cfg_bitstream_loader: BITSTREAM_WORDS out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_GAP, ST_HDR, ST_DUMMY, ST_DATA, ST_PASSIVE, ST_DONE
  } state_t;

  localparam int          WAIT_CYC = cfg_loader_pkg::WAKE_WAIT_CYC;
  localparam logic [2:0]  SLOT_END = 3'(cfg_loader_pkg::SLOT_CYC - 1);
  localparam logic [16:0] LAST_WORD = 17'(BITSTREAM_WORDS - 1);

  state_t                   state;
  state_t                   next_state;
  logic [10:0]              sync1;
  logic [10:0]              sync2;
  logic                     rst_pin_d;
  cfg_loader_pkg::strap_t   strap;
  logic [2:0]               slot_cnt;
  logic [5:0]               bits_left;
  logic [5:0]               next_bits_left;
  logic [31:0]              tx_sr;
  logic [31:0]              next_tx;
  logic [31:0]              rx_sr;
  logic [5:0]               word_slot;
  logic [cfg_loader_pkg::WAIT_W-1:0] wait_cnt;
  logic [16:0]              word_cnt;
  logic                     tgl_d;
  logic                     arm;
  cfg_loader_pkg::cell_wr_t wr;
  logic [3:0]               next_oe;

  // Link-side state
  logic [4:0]               lk_sync1;
  logic [4:0]               lk_sync2;
  logic [31:0]              lk_acc;
  logic [31:0]              lk_word;
  logic [5:0]               lk_beat;
  logic                     lk_tgl;

  // Pin and cross-domain inputs, two flip-flops each
  wire [10:0] pins_raw = {cfg_reset_low_in, mode_in, width_in, spi_io_in, lk_tgl};

  wire                        rst_pin_s = sync2[10];
  wire cfg_loader_pkg::cfg_mode_t pin_mode = cfg_loader_pkg::cfg_mode_t'(sync2[9:8]);
  wire [2:0]                  pin_wcode = sync2[7:5];
  wire [3:0]                  miso      = sync2[4:1];
  wire                        tgl_s     = sync2[0];

  wire release_edge = rst_pin_s && !rst_pin_d;
  wire shifting     = (state == ST_WAKE) || (state == ST_HDR) || (state == ST_DUMMY) || (state == ST_DATA);
  wire next_shift   = (next_state == ST_WAKE) || (next_state == ST_HDR) ||
                      (next_state == ST_DUMMY) || (next_state == ST_DATA);
  wire slot_end     = shifting && (slot_cnt == SLOT_END);
  wire phase_end    = slot_end && (bits_left == 6'h1);
  wire wait_end     = wait_cnt == (cfg_loader_pkg::WAIT_W)'(WAIT_CYC - 1);
  wire [2:0] next_slot = (shifting && !slot_end) ? 3'(slot_cnt + 3'h1) : 3'h0;

  wire active_ok  = (pin_mode == cfg_loader_pkg::MODE_ACTIVE) && (pin_wcode <= cfg_loader_pkg::WCODE_ACTIVE_MAX);
  wire passive_ok = (pin_mode == cfg_loader_pkg::MODE_PASSIVE) && (pin_wcode <= cfg_loader_pkg::WCODE_MAX);
  wire jtag_ok    = pin_mode == cfg_loader_pkg::MODE_JTAG;
  wire [2:0] cap_wcode = jtag_ok ? cfg_loader_pkg::WCODE_X1 : pin_wcode;

  wire [5:0] slots_per_word = 6'(cfg_loader_pkg::WORD_BITS >> strap.wcode);
  wire       word_end = slot_end && (state == ST_DATA) && (word_slot == slots_per_word - 6'h1);
  wire [31:0] rx_next = (strap.wcode == cfg_loader_pkg::WCODE_X1) ? {rx_sr[30:0], miso[1]} :
                        (strap.wcode == cfg_loader_pkg::WCODE_X2) ? {rx_sr[29:0], miso[1:0]} :
                                                                    {rx_sr[27:0], miso};
  wire act_wr    = word_end;
  wire pas_wr    = (state == ST_PASSIVE) && (tgl_s ^ tgl_d);
  wire last_word = word_cnt == LAST_WORD;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (release_edge && active_ok) begin
          next_state = ST_WAKE;
        end else if (release_edge && (passive_ok || jtag_ok)) begin
          next_state = ST_PASSIVE;
        end
      end
      ST_WAKE: begin
        if (phase_end) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (wait_end) begin
          next_state = ST_HDR;
        end
      end
      ST_HDR: begin
        if (phase_end) begin
          next_state = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (phase_end) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (word_end && last_word) begin
          next_state = ST_DONE;
        end
      end
      ST_PASSIVE: begin
        if (pas_wr && last_word) begin
          next_state = ST_DONE;
        end
      end
      default: begin
        next_state = ST_DONE;
      end
    endcase
    if (!rst_pin_s) begin
      next_state = ST_IDLE;
    end
  end

  always_comb begin
    next_bits_left = bits_left;
    next_tx        = tx_sr;
    if (state != next_state) begin
      case (next_state)
        ST_WAKE: begin
          next_bits_left = 6'(cfg_loader_pkg::CMD_BITS);
          next_tx        = {cfg_loader_pkg::WAKE_OPCODE, 24'h000000};
        end
        ST_HDR: begin
          next_bits_left = 6'(cfg_loader_pkg::HDR_BITS);
          next_tx        = {cfg_loader_pkg::FAST_READ_OPCODE, cfg_loader_pkg::READ_START_ADDR};
        end
        ST_DUMMY: begin
          next_bits_left = 6'(cfg_loader_pkg::DUMMY_SLOTS);
          next_tx        = 32'h0;
        end
        default: begin
          next_bits_left = 6'h0;
          next_tx        = 32'h0;
        end
      endcase
    end else if (slot_end) begin
      next_bits_left = bits_left - 6'h1;
      next_tx        = {tx_sr[30:0], 1'b0};
    end
  end

  // Command lanes: io0 out, io2/io3 held high as inactive write-protect and hold
  always_comb begin
    next_oe = 4'h0;
    if (next_state == ST_DATA) begin
      next_oe = (strap.wcode == cfg_loader_pkg::WCODE_ACTIVE_MAX) ? 4'h0 : 4'hc;
    end else if (next_shift) begin
      next_oe = 4'hd;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    sync1 <= pins_raw;
    sync2 <= sync1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state     <= ST_IDLE;
      // Pin idles high: no false start if it is already high at release
      rst_pin_d <= 1'b1;
      strap     <= '0;
      tgl_d     <= 1'b0;
      arm       <= 1'b0;
    end else begin
      state     <= next_state;
      rst_pin_d <= rst_pin_s;
      tgl_d     <= tgl_s;
      arm       <= next_state == ST_PASSIVE;
      if (state == ST_IDLE && release_edge) begin
        strap <= '{mode: pin_mode, wcode: cap_wcode};
      end
    end
  end

  // Flash clock from the system clock divider
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      slot_cnt       <= 3'h0;
      bits_left      <= 6'h0;
      tx_sr          <= 32'h0;
      wait_cnt       <= '0;
      spi_clk_out    <= 1'b0;
      spi_cs_low_out <= 1'b1;
      spi_io_out     <= 4'h0;
      spi_io_oe_out  <= 4'h0;
    end else begin
      slot_cnt       <= next_slot;
      bits_left      <= next_bits_left;
      tx_sr          <= next_tx;
      wait_cnt       <= (state == ST_GAP) ? wait_cnt + 1'b1 : '0;
      spi_clk_out    <= next_shift && (next_slot >= 3'(cfg_loader_pkg::SCLK_HALF));
      spi_cs_low_out <= !next_shift;
      spi_io_out     <= {2'b11, 1'b0, next_tx[31]};
      spi_io_oe_out  <= next_oe;
    end
  end

  // Words land in cell memory, user mode after the last
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || (state == ST_IDLE)) begin
      rx_sr           <= 32'h0;
      word_slot       <= 6'h0;
      word_cnt        <= 17'h0;
      wr              <= '0;
      cfg_done_out    <= 1'b0;
      user_enable_out <= 1'b0;
    end else begin
      if (slot_end && state == ST_DATA) begin
        rx_sr     <= rx_next;
        word_slot <= word_end ? 6'h0 : word_slot + 6'h1;
      end
      if (act_wr || pas_wr) begin
        word_cnt <= word_cnt + 17'h1;
      end
      wr              <= '{en: act_wr || pas_wr, addr: word_cnt[15:0], data: act_wr ? rx_next : lk_word};
      cfg_done_out    <= state == ST_DONE;
      user_enable_out <= state == ST_DONE;
    end
  end

  cfg_cell_mem #(
    .DEPTH(BITSTREAM_WORDS)
  ) u_cells (
    .clk_in     (sys_clk_in),
    .resetn_in  (resetn_in),
    .wr_in      (wr),
    .rd_addr_in (user_rd_addr_in),
    .rd_data_out(user_rd_data_out)
  );

  // Link domain: passive and JTAG data, words handed over by a toggle
  wire        lk_run   = lk_sync2[4];
  wire        lk_arm   = lk_sync2[3];
  wire [2:0]  lk_wcode = lk_sync2[2:0];
  wire [5:0]  lane_w   = 6'(6'h1 << lk_wcode);
  wire [31:0] lane_mask = (lane_w == 6'd32) ? 32'hffffffff : ((32'h1 << lane_w) - 32'h1);
  wire [31:0] lk_next  = (lane_w == 6'd32) ? link_data_in : ((lk_acc << lane_w) | (link_data_in & lane_mask));
  wire [5:0]  lk_beats = 6'(cfg_loader_pkg::WORD_BITS >> lk_wcode);

  always_ff @(posedge link_clk_in) begin
    lk_sync1 <= {resetn_in, arm, strap.wcode};
    lk_sync2 <= lk_sync1;
  end

  // Master clocks data in while select is low
  always_ff @(posedge link_clk_in) begin
    if (!lk_run) begin
      lk_acc  <= 32'h0;
      lk_word <= 32'h0;
      lk_beat <= 6'h0;
      lk_tgl  <= 1'b0;
    end else if (!lk_arm) begin
      lk_acc  <= 32'h0;
      lk_beat <= 6'h0;
    end else if (!link_sel_low_in) begin
      lk_acc <= lk_next;
      if (lk_beat == lk_beats - 6'h1) begin
        lk_beat <= 6'h0;
        lk_word <= lk_next;
        lk_tgl  <= !lk_tgl;
      end else begin
        lk_beat <= lk_beat + 6'h1;
      end
    end
  end

  sequence s_wake_to_gap;
    (state == ST_WAKE) ##1 (state == ST_GAP);
  endsequence

  sequence s_gap_to_hdr;
    (state == ST_GAP) ##1 (state == ST_HDR);
  endsequence

  a_start_on_release: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (state == ST_IDLE && release_edge && active_ok) |=> (state == ST_WAKE && !spi_cs_low_out))
    else $error("active load did not start on reset release");

  a_user_after_all: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    user_enable_out |-> ($past(state) == ST_DONE && word_cnt == 17'(BITSTREAM_WORDS)))
    else $error("user mode before all words loaded");

  a_sclk_high_four: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || !rst_pin_s)
    $rose(spi_clk_out) |-> spi_clk_out[*4] ##1 !spi_clk_out)
    else $error("flash clock high phase not four cycles");

  a_wake_before_read: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    s_wake_to_gap |-> spi_cs_low_out && (wait_cnt == '0))
    else $error("wake phase did not end with select released");

  a_wake_gap_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    s_gap_to_hdr |-> $past(wait_cnt) == (cfg_loader_pkg::WAIT_W)'(WAIT_CYC - 1))
    else $error("read command sent before wake wait elapsed");

  a_read_addr_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (state == ST_HDR && bits_left <= 6'd24 && bits_left != 6'h0) |-> (spi_io_out[0] == 1'b0))
    else $error("read address bit not zero");

  a_jtag_one_bit: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (state == ST_PASSIVE && strap.mode == cfg_loader_pkg::MODE_JTAG) |-> strap.wcode == cfg_loader_pkg::WCODE_X1)
    else $error("jtag load not one bit wide");

  a_active_width: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    shifting |-> (strap.mode == cfg_loader_pkg::MODE_ACTIVE && strap.wcode <= cfg_loader_pkg::WCODE_ACTIVE_MAX))
    else $error("active load with unsupported width");

  a_no_reissue: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (state == ST_DATA && rst_pin_s) |=> (state == ST_DATA || state == ST_DONE))
    else $error("data phase left before last word");

  a_word_count: assert property (@(posedge sys_clk_in) disable iff (!resetn_in || state == ST_IDLE)
    wr.en |-> (word_cnt == {1'b0, wr.addr} + 17'h1))
    else $error("word counter out of step with writes");
endmodule
`default_nettype wire

//--- testbench/flash_model.sv
// Purpose: Serial flash partner for active-mode loads
// Assumes: Command bits taken on clock rise, data changed on clock fall
// Notes:   Word k of the image is {salt, ~salt, 8'h3c, k}; undriven lanes toggle
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic        sck_in,
  input  wire logic        cs_low_in,
  input  wire logic        cmd_in,
  input  wire logic        restart_in,
  input  wire logic [2:0]  wcode_in,
  input  wire logic [7:0]  salt_in,
  output logic      [3:0]  io_out,
  output logic      [7:0]  wake_op_out,
  output logic      [31:0] header_out,
  output logic      [31:0] gap_ns_out,
  output logic      [3:0]  frames_out
);
  int          rises = 0;
  int          n = 0;
  int          w = 1;
  logic [31:0] sh = 32'h0;
  realtime     wake_end = 0;

  function automatic logic image_bit(input int i);
    logic [31:0] word;
    word = {salt_in, ~salt_in, 8'h3c, i[12:5]};
    return word[31 - (i % 32)];
  endfunction

  initial begin
    io_out = 4'h5;
    frames_out = 4'h0;
  end
  always @(negedge restart_in) begin
    frames_out = 4'h0;
    wake_op_out = 8'h00;
    header_out = 32'h0;
  end
  always @(negedge cs_low_in) begin
    rises = 0;
    n = 0;
    if (frames_out == 4'h1) gap_ns_out = 32'(int'($realtime - wake_end));
    frames_out = frames_out + 4'h1;
  end
  // Deselected: lanes released, show a changing pattern
  always @(posedge cs_low_in) begin
    if (frames_out == 4'h1) begin
      wake_op_out = sh[7:0];
      wake_end = $realtime;
    end
    io_out = ~io_out;
  end
  always @(posedge sck_in) if (!cs_low_in) begin
    sh = {sh[30:0], cmd_in};
    rises++;
    if (rises == 32 && frames_out == 4'h2) header_out = sh;
  end
  // Image only after wake and fast read at zero, lanes by width
  always @(negedge sck_in) if (!cs_low_in) begin
    io_out = ~io_out;
    if (rises >= 40 && wake_op_out == cfg_loader_pkg::WAKE_OPCODE &&
        header_out == {cfg_loader_pkg::FAST_READ_OPCODE, 24'h000000}) begin
      w = 1 << wcode_in;
      if (w == 1) io_out[1] = image_bit(n);
      else for (int l = 0; l < w; l++) io_out[l] = image_bit(n + w - 1 - l);
      n += w;
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the bitstream loader
// Assumes: 25 MHz system clock, 125 ns link clock only during beats, idle and startup beats included
// Notes:   Four-word image; modes 0 active, 1 passive, 2 jtag, 3 reserved
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int WORDS = 4;
  typedef struct packed { logic [1:0] mode; logic [2:0] wcode; logic ok; } row_t;
  logic        sys_clk = 0, resetn = 0, cfg_rst_low = 0, link_clk = 0, link_sel_low = 1;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  wcode = 3'h0;
  logic [7:0]  salt = 8'h00, wake_op;
  logic [15:0] rd_addr = 16'h0;
  logic [31:0] link_data = 32'h0, rd_data, header, gap_ns;
  logic [3:0]  io_in, io_out, io_oe, flash_io, frames;
  logic        sck, cs_low, done, user_en;
  int          err_count = 0, checks_done = 0, cs_falls = 0, falls_at = 0;
  row_t        rows [11];

  always #20 sys_clk = ~sys_clk;
  assign io_in = (io_oe & io_out) | (~io_oe & flash_io);
  always @(negedge cs_low) cs_falls++;

  cfg_bitstream_loader #(.BITSTREAM_WORDS(WORDS)) DUT (
    .sys_clk_in(sys_clk), .resetn_in(resetn), .cfg_reset_low_in(cfg_rst_low), .mode_in(mode),
    .width_in(wcode), .spi_io_in(io_in), .link_clk_in(link_clk), .link_sel_low_in(link_sel_low),
    .link_data_in(link_data), .user_rd_addr_in(rd_addr), .spi_clk_out(sck), .spi_cs_low_out(cs_low),
    .spi_io_out(io_out), .spi_io_oe_out(io_oe), .cfg_done_out(done), .user_enable_out(user_en),
    .user_rd_data_out(rd_data));

  flash_model flash (
    .sck_in(sck), .cs_low_in(cs_low), .cmd_in(io_out[0]), .restart_in(cfg_rst_low), .wcode_in(wcode),
    .salt_in(salt), .io_out(flash_io), .wake_op_out(wake_op), .header_out(header), .gap_ns_out(gap_ns),
    .frames_out(frames));

  function automatic logic [31:0] word_of(input logic [7:0] s, input int k);
    return {s, ~s, 8'h3c, k[7:0]};
  endfunction

  task automatic test_done();
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic beat(input logic sel, input logic [31:0] d);
    #1;
    link_sel_low = sel;
    link_data = d;
    #61.5 link_clk = 0;
    #62.5 link_clk = 1;
  endtask

  task automatic reset_values();
    check("rst_clk", sck, 0);
    check("rst_select", cs_low, 1);
    check("rst_oe", io_oe, 0);
    check("rst_done", done, 0);
    check("rst_user", user_en, 0);
    check("rst_rd_data", rd_data, 0);
  endtask

  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && done !== 1'b1; i++) begin
      check("user_enable_early", user_en, 0);
      cyc();
    end
    check("cfg_done", done, 1);
  endtask

  // Master drives link
  // Lanes go MSB first; one idle beat between words keeps x32 spacing legal
  task automatic link_send(input int lanes, input logic [7:0] s);
    logic [31:0] wd, mask, chunk;
    mask = 32'hffffffff >> (32 - lanes);
    repeat (3) beat(1, 32'h5a5a5a5a);
    for (int k = 0; k < WORDS; k++) begin
      wd = word_of(s, k);
      for (int b = 0; b < 32 / lanes; b++) begin
        chunk = (wd << (lanes * b)) >> (32 - lanes);
        beat(0, (~wd & ~mask) | (chunk & mask));
      end
      beat(1, ~wd);
    end
  endtask

  task automatic rd_check(input int k, input logic [31:0] exp);
    cyc();
    rd_addr = k[15:0];
    cyc();
    check("cell_word", rd_data, exp);
  endtask

  task automatic load(input row_t r, input logic [7:0] s);
    cyc();
    mode = r.mode;
    wcode = r.wcode;
    salt = s;
    cfg_rst_low = 0;
    repeat (6) cyc();
    check("done_cleared", done, 0);
    falls_at = cs_falls;
    cfg_rst_low = 1;
    if (!r.ok) begin
      repeat (300) cyc();
      check("refused_select", cs_falls - falls_at, 0);
      check("refused_done", done, 0);
    end else if (r.mode == 2'h0) begin
      wait_done(6000);
      check("wake_opcode", wake_op, cfg_loader_pkg::WAKE_OPCODE);
      check("wake_gap", gap_ns >= 30000, 1);
      check("read_header", header, {cfg_loader_pkg::FAST_READ_OPCODE, 24'h000000});
      check("frames", frames, 2);
    end else begin
      repeat (10) cyc();
      link_send((r.mode == 2'h2) ? 1 : (1 << r.wcode), s);
      wait_done(300);
    end
    if (r.ok) begin
      check("user_enable", user_en, 1);
      check("select_idle", cs_low, 1);
      for (int k = 0; k < WORDS; k++) rd_check(k, word_of(s, k));
    end
  endtask

  initial begin
    #(40 * 60000);
    err_count++;
    test_done();
  end

  initial begin
    rows = '{'{2'h0, 3'h0, 1'b1}, '{2'h0, 3'h1, 1'b1}, '{2'h0, 3'h2, 1'b1}, '{2'h1, 3'h0, 1'b1},
             '{2'h1, 3'h1, 1'b1}, '{2'h1, 3'h2, 1'b1}, '{2'h1, 3'h3, 1'b1}, '{2'h1, 3'h4, 1'b1},
             '{2'h1, 3'h5, 1'b1}, '{2'h2, 3'h4, 1'b1}, '{2'h0, 3'h3, 1'b0}};
    fork
      begin
        #62.5 link_clk = 1;
        repeat (3) beat(1, 32'h0);
      end
    join_none
    repeat (8) @(posedge sys_clk);
    #1;
    reset_values();
    resetn = 1;
    foreach (rows[i]) load(rows[i], 8'(8'h10 + i));
    load(row_t'{2'h3, 3'h0, 1'b0}, 8'h66);
    // Abort an active load in its data phase, then load again
    cyc();
    mode = 2'h0;
    wcode = 3'h2;
    cfg_rst_low = 0;
    repeat (6) cyc();
    cfg_rst_low = 1;
    repeat (1200) cyc();
    check("abort_mid_frame", cs_low, 0);
    cfg_rst_low = 0;
    repeat (6) cyc();
    check("abort_select", cs_low, 1);
    check("abort_done", done, 0);
    load(rows[2], 8'h88);
    resetn = 0;
    repeat (3) cyc();
    reset_values();
    resetn = 1;
    // Pin stays high through reset: no new load may start
    falls_at = cs_falls;
    repeat (10) cyc();
    check("post_reset_idle", cs_falls - falls_at, 0);
    check("post_reset_done", done, 0);
    test_done();
  end
endmodule
`default_nettype wire
